/* logic/ppm_pin_mux.sv */
`timescale 1ns/1ps
module ppm_pin_mux #(
  parameter int unsigned PINS = 7
) (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // port data, direction and pull-up, index per ppm_pkg pin order
  input  wire logic [6:0] port_out_data,
  input  wire logic [6:0] port_dir_out,
  input  wire logic [6:0] port_pullup_en,
  output logic      [6:0] port_in_data,
  // digital-input-enable: port A bits 7,6,5,4,3,0 and port B bit 7
  input  wire logic [5:0] porta_din_en,
  input  wire logic       portb_din_en,
  // alternate function selection
  input  wire logic [1:0] sel_a0,
  input  wire logic [1:0] sel_a3,
  input  wire logic       sel_a4_pwm,
  input  wire logic       sel_a5_pwm,
  input  wire logic       sel_b7_pwm,
  input  wire logic       reset_pin_en,
  input  wire logic       xtal_en,
  input  wire logic [1:0] irq0_edge,
  input  wire logic [1:0] irq1_edge,
  input  wire logic       irq1_use_a4,
  input  wire logic       sleep_mode,
  // alternate function sources and sinks
  input  wire logic       wide_pwm0_out,
  input  wire logic       wide_pwm1_out,
  input  wire logic       wide_pwm2_out,
  input  wire logic       timer8_pwm_out,
  input  wire logic       cmp_result_out,
  output logic            cmp_analog_sel,
  output logic            xtal_in_pin,
  output logic            pin_reset_n,
  output logic            ext_irq_line_0,
  output logic            ext_irq_line_1_alt,
  output logic            wake_req,
  // pads: input, output, active-low output enable and pull-up
  input  wire logic [6:0] pad_in,
  output logic      [6:0] pad_out,
  output logic      [6:0] pad_oe_n,
  output logic      [6:0] pad_pullup
);

  // elaboration checks: the pin map and all port widths are fixed at seven pins,
  // and the port B enable bit must be the last entry of the pin order
  initial begin
    if (PINS != ppm_pkg::NUM_PINS) $error("ppm_pin_mux serves exactly seven pins");
    if (ppm_pkg::PIN_B7 != PINS - 1) $error("ppm_pin_mux needs port B bit 7 as its last pin");
  end

  typedef struct packed {
    logic [6:0] sync1;
    logic [6:0] sync2;
    logic [6:0] prev;
    logic [6:0] din;
    logic [6:0] pout;
    logic [6:0] poe_n;
    logic       irq0;
    logic       irq1;
    logic       wake;
    logic       rstn;
    logic [2:0] warm;
  } ppm_state_t;

  ppm_state_t st_q;
  ppm_state_t st_d;
  logic [6:0] din_en;
  logic [6:0] drv;
  logic [6:0] alt_en;
  logic       settled;

  // edge match for one interrupt line
  function automatic logic ppm_edge_hit(input logic [1:0] mode, input logic now, input logic was);
    ppm_edge_hit = 1'b0;
    case (mode)
      ppm_pkg::PPM_EDGE_BOTH: ppm_edge_hit = now ^ was;
      ppm_pkg::PPM_EDGE_RISE: ppm_edge_hit = now & ~was;
      ppm_pkg::PPM_EDGE_FALL: ppm_edge_hit = ~now & was;
      default:                ppm_edge_hit = 1'b0;
    endcase
  endfunction : ppm_edge_hit

  // combined input enables, port B bit on top
  assign din_en = {portb_din_en, porta_din_en};

  // next state: synchronise pads, mux outputs, detect edges
  // pads come from outside the clock domain, so two flops stand before any
  // use; the enable mask sits after them, which makes a disabled pin read a
  // steady zero and keeps it away from the wake and interrupt logic
  always_comb begin
    st_d = st_q;
    // after reset the pipeline still holds zeros: a pad idling high would
    // look like a rising edge, so edge logic waits for the settle count
    settled   = (st_q.warm == ppm_pkg::SETTLE_EDGES);
    st_d.warm = settled ? st_q.warm : st_q.warm + 3'h1;
    st_d.sync1 = pad_in;
    st_d.sync2 = st_q.sync1;
    st_d.prev  = st_q.din;
    st_d.din   = st_q.sync2 & din_en;
    drv    = port_out_data;
    alt_en = 7'h00;
    // port A bit 0: comparator result or wide pwm0
    case (sel_a0)
      ppm_pkg::PPM_SEL_WIDE: begin
        drv[ppm_pkg::PIN_A0]    = wide_pwm0_out;
        alt_en[ppm_pkg::PIN_A0] = 1'b1;
      end
      ppm_pkg::PPM_SEL_ALT2: begin
        drv[ppm_pkg::PIN_A0]    = cmp_result_out;
        alt_en[ppm_pkg::PIN_A0] = 1'b1;
      end
      default: ;
    endcase
    // port A bit 3: timer8 pwm or wide pwm2
    case (sel_a3)
      ppm_pkg::PPM_SEL_WIDE: begin
        drv[ppm_pkg::PIN_A3]    = wide_pwm2_out;
        alt_en[ppm_pkg::PIN_A3] = 1'b1;
      end
      ppm_pkg::PPM_SEL_ALT2: begin
        drv[ppm_pkg::PIN_A3]    = timer8_pwm_out;
        alt_en[ppm_pkg::PIN_A3] = 1'b1;
      end
      default: ;
    endcase
    if (sel_a4_pwm) begin
      drv[ppm_pkg::PIN_A4]    = wide_pwm1_out;
      alt_en[ppm_pkg::PIN_A4] = 1'b1;
    end
    if (sel_b7_pwm) begin
      drv[ppm_pkg::PIN_B7]    = wide_pwm1_out;
      alt_en[ppm_pkg::PIN_B7] = 1'b1;
    end
    if (sel_a5_pwm) begin
      drv[ppm_pkg::PIN_A5]    = wide_pwm2_out;
      alt_en[ppm_pkg::PIN_A5] = 1'b1;
    end
    // alternate function takes the pin over the port bit
    // an enabled alternate output also turns the driver on, so software
    // need not set the direction bit for a routed pwm or comparator output
    st_d.pout  = drv;
    st_d.poe_n = ~(port_dir_out | alt_en);
    // open drain on A5: only drive low, float for a one
    // the pad data stays low at all times and the enable carries the level,
    // so no select or direction setting can ever push the pin high
    st_d.pout[ppm_pkg::PIN_A5]  = 1'b0;
    st_d.poe_n[ppm_pkg::PIN_A5] = ~((port_dir_out[ppm_pkg::PIN_A5] | alt_en[ppm_pkg::PIN_A5])
                                    & ~drv[ppm_pkg::PIN_A5]);
    // reset input function releases A5 entirely
    if (reset_pin_en) begin
      st_d.poe_n[ppm_pkg::PIN_A5] = 1'b1;
    end
    // crystal owns A7 and A6, no digital drive
    // the input enables of these pins are left to software, which must
    // clear them to stop the input buffers drawing current
    if (xtal_en) begin
      st_d.poe_n[ppm_pkg::PIN_A7] = 1'b1;
      st_d.poe_n[ppm_pkg::PIN_A6] = 1'b1;
    end
    st_d.rstn = reset_pin_en ? st_q.sync2[ppm_pkg::PIN_A5] : 1'b1;
    // interrupt lines look at masked inputs, so a disabled pin cut off while high gives at most one falling edge
    st_d.irq0 = settled &
                ppm_edge_hit(irq0_edge, st_q.din[ppm_pkg::PIN_A0], st_q.prev[ppm_pkg::PIN_A0]);
    st_d.irq1 = settled & irq1_use_a4 &
                ppm_edge_hit(irq1_edge, st_q.din[ppm_pkg::PIN_A4], st_q.prev[ppm_pkg::PIN_A4]);
    // toggle wake-up only from enabled pins
    // the enable is applied twice: once in the input mask and once here, so
    // a pin cut off in the same cycle as its toggle still cannot wake
    st_d.wake = settled & sleep_mode & (|((st_q.din ^ st_q.prev) & din_en));
    // synchronous reset: all drivers released, pulses and pipeline cleared
    if (rst) begin
      st_d       = '0;
      st_d.poe_n = ppm_pkg::RST_OE_N;
      st_d.rstn  = 1'b1;
    end
  end

  // state register
  always_ff @(posedge sys_clk) begin
    st_q <= st_d;
  end

  // outputs straight from the state register, apart from the constant xtal_in_pin and the level pass-through
  // of the pull-up enables and the analog select, which follow their inputs
  assign port_in_data       = st_q.din;
  assign pad_out            = st_q.pout;
  assign pad_oe_n           = st_q.poe_n;
  assign pad_pullup         = port_pullup_en;
  assign ext_irq_line_0     = st_q.irq0;
  assign ext_irq_line_1_alt = st_q.irq1;
  assign wake_req           = st_q.wake;
  assign pin_reset_n        = st_q.rstn;
  assign xtal_in_pin        = 1'b0; // analog path, no digital copy
  assign cmp_analog_sel     = ~(din_en[ppm_pkg::PIN_A4] & din_en[ppm_pkg::PIN_A3] & portb_din_en);

endmodule : ppm_pin_mux

/* logic/ppm_pkg.sv */
package ppm_pkg;
  // pin indices inside the seven-pin group
  localparam int unsigned PIN_A7 = 0;
  localparam int unsigned PIN_A6 = 1;
  localparam int unsigned PIN_A5 = 2;
  localparam int unsigned PIN_A4 = 3;
  localparam int unsigned PIN_A3 = 4;
  localparam int unsigned PIN_A0 = 5;
  localparam int unsigned PIN_B7 = 6;
  localparam int unsigned NUM_PINS = 7;
  // reset values of the configuration state
  localparam logic [6:0] RST_PINS = 7'h00;
  localparam logic [6:0] RST_OE_N = 7'h7F;
  // edges after reset before the pin pipeline holds real pad levels
  localparam logic [2:0] SETTLE_EDGES = 3'h4;
  // output selector codes for the two-bit selects of A0 and A3
  typedef enum logic [1:0] {
    PPM_SEL_PORT  = 2'h0,
    PPM_SEL_WIDE  = 2'h1,
    PPM_SEL_ALT2  = 2'h2,
    PPM_SEL_ALT3  = 2'h3
  } ppm_sel_t;
  // edge selection for external interrupt lines
  typedef enum logic [1:0] {
    PPM_EDGE_BOTH = 2'h0,
    PPM_EDGE_RISE = 2'h1,
    PPM_EDGE_FALL = 2'h2,
    PPM_EDGE_NONE = 2'h3
  } ppm_edge_t;
endpackage : ppm_pkg

/* dv/ppm_pin_mux_monitor.sv */
`timescale 1ns/1ps
module ppm_pin_mux_monitor (
  input wire logic       sys_clk, rst, reset_pin_en, cmp_result_out, ext_irq_line_0, wake_req, portb_din_en,
  input wire logic [1:0] sel_a0, irq0_edge,
  input wire logic [5:0] porta_din_en,
  input wire logic [6:0] port_out_data, port_dir_out, pad_in, pad_out, pad_oe_n, port_in_data
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // pin drive, routing, interrupts and input gating
  a5_no_high_a: assert property (!pad_oe_n[2] |-> !pad_out[2]) else $error("A5 high");
  port_drive_a: assert property (port_dir_out[5] && sel_a0 == 2'h0 |=>
    !pad_oe_n[5] && pad_out[5] == $past(port_out_data[5])) else $error("A0 port drive");
  cmp_route_a: assert property (sel_a0 == 2'h2 |=> pad_out[5] == $past(cmp_result_out)) else $error("cmp");
  reset_hiz_a: assert property (reset_pin_en |=> pad_oe_n[2]) else $error("A5 driven");
  rise_irq_a: assert property ($rose(pad_in[5]) && porta_din_en[5] && irq0_edge == 2'h1 |->
    ##[3:5] ext_irq_line_0) else $error("no irq");
  no_irq_a: assert property ((irq0_edge == 2'h3)[*6] |-> !ext_irq_line_0) else $error("irq off");
  off_read_a: assert property ((!porta_din_en[5])[*2] |-> !port_in_data[5]) else $error("read");
  wake_off_a: assert property ((porta_din_en == 6'h00 && !portb_din_en)[*6] |-> !wake_req)
    else $error("wake");
  // main scenarios
  cover property (ext_irq_line_0);
  cover property (wake_req);
  cover property (sel_a0 == 2'h2 ##1 pad_out[5]);
endmodule : ppm_pin_mux_monitor
bind ppm_pin_mux ppm_pin_mux_monitor i_ppm_pin_mux_monitor (.*);

/* dv/ppm_pad_model.sv */
`timescale 1ns/1ps
module ppm_pad_model (
  input  wire logic       sys_clk,
  input  wire logic [6:0] pad_out, pad_oe_n, pad_pullup, ext_en, ext_val,
  output logic      [6:0] pad_in
);
  logic [6:0] flt_q = 7'h00;
  // a line nobody holds wanders each cycle
  always_ff @(posedge sys_clk) flt_q <= ~flt_q;
  // pin driver, else board driver, else pull-up
  assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & ext_en & ext_val)
    | (pad_oe_n & ~ext_en & (pad_pullup | flt_q));
endmodule : ppm_pad_model

/* dv/ppm_pin_mux_test.sv */
`timescale 1ns/1ps
module ppm_pin_mux_test;
  logic       sys_clk = 1'b0, rst = 1'b1, portb_din_en, sel_a4_pwm, sel_a5_pwm, sel_b7_pwm, reset_pin_en, xtal_en;
  logic       irq1_use_a4, sleep_mode, wide_pwm0_out, wide_pwm1_out, wide_pwm2_out, timer8_pwm_out, cmp_result_out;
  logic [1:0] sel_a0, sel_a3, irq0_edge, irq1_edge;
  logic [5:0] porta_din_en;
  logic [6:0] port_out_data, port_dir_out, port_pullup_en, ext_en, ext_val, last_q = 7'h00, last_e = 7'h00, q[$];
  wire logic [6:0] port_in_data, pad_in, pad_out, pad_oe_n, pad_pullup;
  wire logic  cmp_analog_sel, xtal_in_pin, pin_reset_n, ext_irq_line_0, ext_irq_line_1_alt, wake_req;
  int         miscompares = 0, num_checks = 0, n0 = 0, n1 = 0, nw = 0;
  ppm_pin_mux i_ppm_pin_mux (.*);
  ppm_pad_model i_ppm_pad_model (.*);
  initial forever #10 sys_clk = ~sys_clk;
  task chk(input logic [6:0] seen, input logic [6:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task end_of_test;
    if (q.size() != 0) miscompares++;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  // note the expected read-back of the new inputs, then settle
  task step;
    logic [6:0] l;
    #1 l = port_dir_out[0] ? port_out_data : ext_val;
    if (port_dir_out[0]) begin
      if (sel_a0 != 2'h0 && sel_a0 != 2'h3) l[5] = sel_a0[0] ? wide_pwm0_out : cmp_result_out;
      if (sel_a3 != 2'h0 && sel_a3 != 2'h3) l[4] = sel_a3[0] ? wide_pwm2_out : timer8_pwm_out;
      if (sel_a4_pwm) l[3] = wide_pwm1_out;
      if (sel_b7_pwm) l[6] = wide_pwm1_out;
      if (sel_a5_pwm) l[2] = wide_pwm2_out;
      if (reset_pin_en) l[2] = 1'b1;
      if (xtal_en) l[1:0] = 2'h3;
    end
    l = l & {portb_din_en, porta_din_en};
    if (l !== last_e) q.push_back(l);
    last_e = l;
    repeat (6) @(posedge sys_clk);
  endtask : step
  // each change of the read-back takes the oldest note
  always @(posedge sys_clk) begin
    if (!rst && port_in_data !== last_q) begin
      if (q.size() > 0) chk(port_in_data, q.pop_front());
      else chk(port_in_data, last_q);
      last_q = port_in_data;
    end
    n0 += (ext_irq_line_0 === 1'b1);
    n1 += (ext_irq_line_1_alt === 1'b1);
    nw += (wake_req === 1'b1);
  end
  initial begin
    {port_out_data, port_dir_out, port_pullup_en, ext_val, porta_din_en, portb_din_en, sel_a0, sel_a3} = '0;
    {sel_a4_pwm, sel_a5_pwm, sel_b7_pwm, reset_pin_en, xtal_en, irq0_edge, irq1_edge, irq1_use_a4} = '0;
    {sleep_mode, wide_pwm0_out, wide_pwm1_out, wide_pwm2_out, timer8_pwm_out, cmp_result_out} = '0;
    ext_en = 7'h7F;
    void'($urandom(12));
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    // toggle A0 and A4 under each edge code, last with inputs cut off
    for (int i = 0; i < 5; i++) begin
      @(posedge sys_clk);
      {porta_din_en, portb_din_en, irq1_use_a4, sleep_mode} <= (i < 4) ? 9'h1FF : 9'h003;
      {irq0_edge, irq1_edge} <= {i[1:0], i[1:0]};
      step();
      {n0, n1, nw} = '0;
      ext_val <= 7'h28;
      step();
      ext_val <= 7'h00;
      step();
      chk(7'(n0), (i > 2) ? 7'h0 : (i == 0) ? 7'h2 : 7'h1);
      chk(7'(n1), (i > 2) ? 7'h0 : (i == 0) ? 7'h2 : 7'h1);
      chk(7'(nw != 0), 7'(i < 4));
    end
    $display("edge test done");
    for (int i = 0; i < 14; i++) begin
      @(posedge sys_clk);
      if (i == 12) {porta_din_en, portb_din_en} <= 7'h79;
      else if (i == 13) {ext_val, port_pullup_en} <= 14'h3FFF;
      else if (i[0]) {porta_din_en, portb_din_en} <= 7'($urandom);
      else ext_val <= 7'($urandom);
      step();
    end
    $display("input test done");
    for (int i = 0; i < 24; i++) begin
      @(posedge sys_clk);
      {port_dir_out, ext_en} <= 14'h3F80;
      {port_out_data, sel_a0, sel_a3, sel_a4_pwm, sel_a5_pwm, sel_b7_pwm, reset_pin_en, xtal_en, wide_pwm0_out,
        wide_pwm1_out, wide_pwm2_out, timer8_pwm_out, cmp_result_out} <= 21'($urandom);
      step();
    end
    $display("output test done");
    @(posedge sys_clk);
    porta_din_en <= 6'h34;
    step();
    chk(7'(cmp_analog_sel), 7'h1);
    @(posedge sys_clk);
    {port_dir_out, ext_val, port_pullup_en} <= 21'h000055;
    ext_en <= 7'h7F;
    {port_out_data, sel_a0, sel_a3, sel_a4_pwm, sel_a5_pwm, sel_b7_pwm, reset_pin_en, xtal_en, wide_pwm0_out,
      wide_pwm1_out, wide_pwm2_out, timer8_pwm_out, cmp_result_out} <= 21'h000040;
    step();
    chk(7'({pin_reset_n, cmp_analog_sel, xtal_in_pin}), 7'h2);
    chk(pad_pullup, 7'h55);
    $display("pin function test done");
    end_of_test();
  end
  initial begin
    #100000;
    miscompares++;
    end_of_test();
  end
endmodule : ppm_pin_mux_test
